// ==== bench/tcs_top_sva.sv ====
//==============================================================================
// Port-level checks of the time-out counter and status latch.
module tcs_top_sva #(
	parameter POR_BASE_CYCLES = 1024,
	parameter ATR_MAX_CLOCKS  = 384
) (
	input wire       i_mclk,
	input wire       i_resetn,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	input wire       i_vcc_prot,
	input wire       i_rst_prot,
	input wire       i_card_present_status,
	input wire       i_overheat,
	input wire       i_shutdown_n_in,
	input wire       i_count_tick,
	input wire       i_session_start,
	input wire       o_irq_n_out,
	input wire       o_first_timeout_flag,
	input wire       o_third_timeout_flag,
	input wire       o_atr_min_reached,
	input wire       o_atr_max_reached,
	input wire       o_por_active
);
	logic [7:0] cfg_r;

	// Last configuration byte written; undefined codes must leave every time-out counter quiet.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			cfg_r <= 8'h00;
		else if (i_wr && i_addr == 4'h8)
			cfg_r <= i_wdata;
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	//==========================================================================
	// Assertions.
	AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside the read answer cycle");
	AST_POR_IRQ: assert property (o_por_active [*3] |-> !o_irq_n_out)
		else $error("interrupt released during the power-on pulse");
	AST_VCC_IRQ: assert property (i_vcc_prot [*5] |-> !o_irq_n_out)
		else $error("supply fault did not hold the interrupt");
	AST_RSTP_IRQ: assert property (i_rst_prot [*5] |-> !o_irq_n_out)
		else $error("reset-line fault did not hold the interrupt");
	AST_HEAT_IRQ: assert property (i_overheat [*5] |-> !o_irq_n_out)
		else $error("overheat did not hold the interrupt");
	AST_SHUTDOWN_FLAG_IRQ: assert property (!i_shutdown_n_in [*5] |-> !o_irq_n_out)
		else $error("shut-down did not hold the interrupt");
	AST_PRES_IRQ: assert property ($changed(i_card_present_status) |-> ##[3:4] !o_irq_n_out)
		else $error("presence change did not raise the interrupt");
	AST_THIRD_TICK: assert property (o_third_timeout_flag |-> $past(i_count_tick))
		else $error("third time-out pulse without a count tick");
	AST_FIRST_TICK: assert property (o_first_timeout_flag |-> $past(i_count_tick))
		else $error("first time-out pulse without a count tick");
	AST_STOP3: assert property (!(cfg_r inside {8'h61, 8'h65, 8'h68}) |=> !o_third_timeout_flag)
		else $error("wide counter fired while stopped");
	AST_STOP1: assert property (!(cfg_r inside {8'h05, 8'h65}) |=> !o_first_timeout_flag)
		else $error("counter 1 fired while stopped");
	AST_ATR_CLR: assert property (!i_session_start |=> !o_atr_min_reached && !o_atr_max_reached)
		else $error("answer window flag outside a session");
	AST_ATR_ORDER: assert property (o_atr_max_reached |-> o_atr_min_reached)
		else $error("maximum window before minimum window");

	// Main scenarios that the bench must reach.
	cover property (o_third_timeout_flag);
	cover property (o_first_timeout_flag);
	cover property ($rose(o_atr_max_reached));
	cover property ($fell(o_por_active));
endmodule // tcs_top_sva

bind tcs_top tcs_top_sva #(
	.POR_BASE_CYCLES(POR_BASE_CYCLES), .ATR_MAX_CLOCKS(ATR_MAX_CLOCKS)
) i_sva (
	.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vcc_prot(i_vcc_prot),
	.i_rst_prot(i_rst_prot), .i_card_present_status(i_card_present_status),
	.i_overheat(i_overheat), .i_shutdown_n_in(i_shutdown_n_in),
	.i_count_tick(i_count_tick), .i_session_start(i_session_start),
	.o_irq_n_out(o_irq_n_out), .o_first_timeout_flag(o_first_timeout_flag),
	.o_third_timeout_flag(o_third_timeout_flag), .o_atr_min_reached(o_atr_min_reached),
	.o_atr_max_reached(o_atr_max_reached), .o_por_active(o_por_active)
);

// ==== bench/tcs_top_tb.sv ====
//==============================================================================
// Self-checking bench of the time-out counter and status latch.
module tcs_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam POR_B   = 8;
	localparam ATR_MAX = 384;
	logic       i_mclk          = 1'b0;
	logic       i_resetn        = 1'b0;
	logic [3:0] i_addr          = 4'h0;
	logic [7:0] i_wdata         = 8'h00;
	logic       i_wr            = 1'b0;
	logic       i_rd            = 1'b0;
	logic [4:0] flt             = 5'h00;
	logic       i_supply_fail   = 1'b0;
	logic       i_card_io       = 1'b1;
	logic       i_count_tick    = 1'b0;
	logic       i_session_start = 1'b0;
	logic       i_card_clk_tick = 1'b0;
	wire  [7:0] o_rdata;
	wire        irq_n, first_p, third_p, atr_min, atr_max, por_act;
	int         n_fail          = 0;
	int         num_checks      = 0;
	int         por_wait        = 0;

	// The strap is tied: a longer pulse leaves room for reads inside it.
	tcs_top #(.POR_BASE_CYCLES(POR_B), .ATR_MAX_CLOCKS(ATR_MAX)) i_dut (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vcc_prot(flt[0]),
		.i_rst_prot(flt[1]), .i_card_present_status(flt[2]), .i_overheat(flt[3]),
		.i_shutdown_n_in(!flt[4]), .i_supply_fail(i_supply_fail),
		.i_por_delay_setting(2'b10), .i_card_io(i_card_io), .i_count_tick(i_count_tick),
		.i_session_start(i_session_start), .i_card_clk_tick(i_card_clk_tick),
		.o_irq_n_out(irq_n), .o_first_timeout_flag(first_p), .o_third_timeout_flag(third_p),
		.o_atr_min_reached(atr_min), .o_atr_max_reached(atr_max), .o_por_active(por_act));

	// A 50 ns period gives the 20 MHz system clock.
	always #25 i_mclk = ~i_mclk;

	//==========================================================================
	// Shared tasks.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic final_report;
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(nm, e, o_rdata);
	endtask

	// Waits for the power-on pulse to end, then lets the interrupt settle.
	task automatic wait_por;
		int k;
		for (k = 0; k < 200 && por_act !== 1'b0; k++) begin
			@(posedge i_mclk);
			#1;
		end
		por_wait = k;
		if (k == 200) begin
			chk("pulse end timeout", 0, 1);
			final_report();
		end
		repeat (3) @(posedge i_mclk);
		#1;
	endtask

	// Pulses one count input every other cycle until the chosen output shows.
	task automatic cnt(input int sel, input int lim, input int e, input string nm);
		int k;
		logic hit;
		hit = 1'b0;
		for (k = 1; k <= lim && !hit; k++) begin
			@(posedge i_mclk);
			if (sel < 2)
				i_count_tick <= 1'b1;
			else
				i_card_clk_tick <= 1'b1;
			@(posedge i_mclk);
			i_count_tick <= 1'b0;
			i_card_clk_tick <= 1'b0;
			#1;
			hit = sel == 0 ? first_p : sel == 1 ? third_p : sel == 2 ? atr_min : atr_max;
		end
		chk(nm, 16'(e), hit === 1'b1 ? 16'(k - 1) : 16'hFFFF);
	endtask

	//==========================================================================
	// Scenarios.
	task automatic t_por(input logic drop);
		if (drop) begin
			@(posedge i_mclk);
			i_supply_fail <= 1'b1;
			@(posedge i_mclk);
			i_supply_fail <= 1'b0;
			repeat (5) @(posedge i_mclk);
			#1;
		end
		chk("pulse running", 1, por_act);
		chk("irq in pulse", 0, irq_n);
		rdc(4'hF, 8'h10, "status in pulse");
		wait_por();
		// The tied strap of two stretches the pulse fourfold; the read used two edges of it.
		if (!drop) chk("pulse length", 16'((POR_B << 2) - 2), 16'(por_wait));
		chk("irq after pulse", 1, irq_n);
		rdc(4'hF, 8'h10, "status after pulse");
		// Flags clear two cycles after the read strobe, so the next read waits one edge.
		@(posedge i_mclk);
		rdc(4'hF, 8'h00, "status cleared");
	endtask

	task automatic t_regs;
		rdc(4'h8, 8'h00, "config reset");
		rdc(4'h9, 8'h00, "reload read");
		wr(4'h3, 8'h55);
		rdc(4'h3, 8'h00, "unmapped read");
		wr(4'h9, 8'h04);
		wr(4'hA, 8'h02);
		wr(4'hB, 8'h00);
		wr(4'h8, 8'h68);
		rdc(4'h8, 8'h68, "config readback");
		cnt(1, 600, 516, "24-bit count");
		wr(4'h8, 8'h00);
		wr(4'hB, 8'h01);
		wr(4'h8, 8'h61);
		cnt(1, 300, 258, "16-bit count");
		cnt(1, 4, -1, "16-bit stopped");
		wr(4'h8, 8'h00);
	endtask

	task automatic t_c65;
		wr(4'h9, 8'h03);
		wr(4'hA, 8'h40);
		wr(4'h8, 8'h65);
		cnt(0, 2, -1, "counter 1 armed");
		@(posedge i_mclk);
		i_card_io <= 1'b0;
		repeat (4) @(posedge i_mclk);
		#1;
		cnt(0, 8, 3, "counter 1 first");
		cnt(0, 8, 3, "counter 1 reload");
		wr(4'h8, 8'h05);
		cnt(0, 8, 3, "counter 1 kept");
		wr(4'h8, 8'h33);
		rdc(4'h8, 8'h33, "undefined readback");
		cnt(0, 8, -1, "undefined stops");
		wr(4'h8, 8'h00);
		@(posedge i_mclk);
		i_card_io <= 1'b1;
	endtask

	// Each fault pin in turn; leaving shut-down also sets the supervisor bit.
	task automatic t_flt;
		logic [7:0] ex [5] = '{8'h20, 8'h20, 8'h04, 8'h01, 8'h90};
		for (int i = 0; i < 5; i++) begin
			@(posedge i_mclk);
			flt <= 5'(1 << i);
			repeat (6) @(posedge i_mclk);
			#1;
			chk("irq on fault", 0, irq_n);
			@(posedge i_mclk);
			flt <= 5'h00;
			repeat (4) @(posedge i_mclk);
			wait_por();
			rdc(4'hF, ex[i], "status fault bits");
			@(posedge i_mclk);
			rdc(4'hF, 8'h00, "status after read");
			repeat (3) @(posedge i_mclk);
			#1;
			chk("irq released", 1, irq_n);
		end
	endtask

	task automatic t_atr;
		@(posedge i_mclk);
		i_session_start <= 1'b1;
		repeat (2) @(posedge i_mclk);
		cnt(2, 250, 200, "answer minimum");
		cnt(3, 250, ATR_MAX - 200, "answer maximum");
		@(posedge i_mclk);
		i_session_start <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1;
		chk("answer flags cleared", 0, {atr_min, atr_max});
	endtask

	// Main sequence: reset for ten cycles, then every scenario once, the power-on pulse twice.
	initial begin
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		#1;
		t_por(1'b0);
		t_regs();
		t_c65();
		t_flt();
		t_por(1'b1);
		t_atr();
		final_report();
	end
endmodule // tcs_top_tb

// ==== rtl/tcs_defines.vh ====
//==============================================================================
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH

//==============================================================================
// Register offsets.
`define TCS_ADDR_TOCFG      4'h8
`define TCS_ADDR_RELOAD_LO  4'h9
`define TCS_ADDR_RELOAD_MID 4'hA
`define TCS_ADDR_RELOAD_HI  4'hB
`define TCS_ADDR_HWSTAT     4'hF

//==============================================================================
// Hardware status bit positions and reset values.
`define TCS_HS_SHUTDOWN_FLAG  7
`define TCS_HS_PROT  5
`define TCS_HS_SUP   4
`define TCS_HS_PRES  2
`define TCS_HS_HEAT  0
`define TCS_CFG_RESET    8'h00
`define TCS_RELOAD_RESET 8'h00

//==============================================================================
// Configuration codes.
`define TCS_CFG_STOP   8'h00
`define TCS_CFG_KEEP1  8'h05
`define TCS_CFG_C16    8'h61
`define TCS_CFG_C8_C16 8'h65
`define TCS_CFG_C24    8'h68

//==============================================================================
// Timing counts.
`define TCS_ATR_MIN_CLOCKS  10'd200
`define TCS_ATR_NMAX        384
`define TCS_POR_BASE_CYCLES 1024
`define TCS_CLR_DELAY       2

`endif

// ==== rtl/tcs_stage.v ====
//==============================================================================
// One 8-bit down-counting stage of the time-out chain.
module tcs_stage #(
	parameter WIDTH = 8
) (
	input  wire             i_mclk,
	input  wire             i_resetn,
	input  wire             i_load,
	input  wire [WIDTH-1:0] i_load_val,
	input  wire             i_dec,
	output reg  [WIDTH-1:0] o_val,
	output wire             o_zero,
	output wire             o_one
);
	// Load wins over decrement so a reload at terminal count is exact.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_val <= {WIDTH{1'b0}};
		end else if (i_load) begin
			o_val <= i_load_val;
		end else if (i_dec) begin
			o_val <= o_val - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign o_zero = (o_val == {WIDTH{1'b0}});
	assign o_one  = (o_val == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // tcs_stage

// ==== rtl/tcs_sync.v ====
//==============================================================================
// Two-stage synchroniser for pin inputs; the first stage feeds only the second.
module tcs_sync #(
	parameter         WIDTH   = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             i_mclk,
	input  wire             i_resetn,
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_r;

	// Both stages reset to the idle level of the pins.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_r <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule // tcs_sync

// ==== rtl/tcs_top.v ====
// Strobed register access was decided locally.
`include "tcs_defines.vh"

//==============================================================================
// Time-out counter and hardware status latch of the card reader.
module tcs_top #(
	parameter POR_BASE_CYCLES = `TCS_POR_BASE_CYCLES,
	parameter ATR_MAX_CLOCKS  = `TCS_ATR_NMAX
) (
	input  wire       i_mclk,
	input  wire       i_resetn,
	input  wire [3:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output wire [7:0] o_rdata,
	input  wire       i_vcc_prot,
	input  wire       i_rst_prot,
	input  wire       i_card_present_status,
	input  wire       i_overheat,
	input  wire       i_shutdown_n_in,
	input  wire       i_supply_fail,
	input  wire [1:0] i_por_delay_setting,
	input  wire       i_card_io,
	input  wire       i_count_tick,
	input  wire       i_session_start,
	input  wire       i_card_clk_tick,
	output wire       o_irq_n_out,
	output wire       o_first_timeout_flag,
	output wire       o_third_timeout_flag,
	output wire       o_atr_min_reached,
	output wire       o_atr_max_reached,
	output wire       o_por_active
);

	//==========================================================================
	// Pin synchronisers.
	wire [8:0] pins_s;
	wire       vcc_prot_s;
	wire       rst_prot_s;
	wire       present_s;
	wire       heat_s;
	wire       shutdown_n_in_s;
	wire       supply_fail_s;
	wire [1:0] delay_s;
	wire       io_s;

	// Idle levels: shut-down released and I/O line high, so reset does not fake an event.
	tcs_sync #(
		.WIDTH   (9),
		.RST_VAL (9'h110)
	) u_sync (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_async  ({i_card_io, i_por_delay_setting, i_supply_fail, i_shutdown_n_in,
		            i_overheat, i_card_present_status, i_rst_prot, i_vcc_prot}),
		.o_sync   (pins_s)
	);

	assign vcc_prot_s    = pins_s[0];
	assign rst_prot_s    = pins_s[1];
	assign present_s     = pins_s[2];
	assign heat_s        = pins_s[3];
	assign shutdown_n_in_s      = pins_s[4];
	assign supply_fail_s = pins_s[5];
	assign delay_s       = pins_s[7:6];
	assign io_s          = pins_s[8];

	//==========================================================================
	// Edge detection on synchronised pins.
	reg shutdown_n_in_prev_r;
	reg supply_fail_prev_r;
	reg present_prev_r;
	reg present_seen_r;
	reg io_prev_r;

	// Presence history is seeded one cycle after reset, before the synchroniser passes the pin, so a card already inserted at reset counts as a change.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			shutdown_n_in_prev_r      <= 1'b1;
			supply_fail_prev_r <= 1'b0;
			present_prev_r     <= 1'b0;
			present_seen_r     <= 1'b0;
			io_prev_r          <= 1'b1;
		end else begin
			shutdown_n_in_prev_r      <= shutdown_n_in_s;
			supply_fail_prev_r <= supply_fail_s;
			present_prev_r     <= present_s;
			present_seen_r     <= 1'b1;
			io_prev_r          <= io_s;
		end
	end

	wire shutdown_flag_leave  = shutdown_n_in_s & ~shutdown_n_in_prev_r;
	wire supply_drop = supply_fail_s & ~supply_fail_prev_r;
	wire por_restart = shutdown_flag_leave | supply_drop;
	wire start_bit   = io_prev_r & ~io_s;

	//==========================================================================
	// Internal power-on reset pulse; its length scales with the delay strap.
	reg        por_active_r;
	reg [19:0] por_cnt_r;
	reg [1:0]  delay_r;
	wire [19:0] por_len = POR_BASE_CYCLES[19:0] << delay_r;

	// The strap is taken once the synchroniser has settled, early in each pulse.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			por_active_r <= 1'b1;
			por_cnt_r    <= 20'h00000;
			delay_r      <= 2'h0;
		end else begin
			if (por_active_r && por_cnt_r == 20'h00003) begin
				delay_r <= delay_s;
			end
			if (por_restart) begin
				por_active_r <= 1'b1;
				por_cnt_r    <= 20'h00000;
			end else if (por_active_r) begin
				if (por_cnt_r == por_len - 20'h00001) begin
					por_active_r <= 1'b0;
				end else begin
					por_cnt_r <= por_cnt_r + 20'h00001;
				end
			end
		end
	end

	//==========================================================================
	// Status read pipeline: flags clear two cycles after the read strobe.
	reg       prot_r;
	reg       sup_r;
	reg       pres_r;
	reg       heat_r;
	reg       shutdown_flag_r;
	reg       rd1_r;
	reg       clr_fire_r;
	reg [7:0] snap_r;
	reg [7:0] clr_mask_r;

	wire       rd_hwstat = i_rd & (i_addr == `TCS_ADDR_HWSTAT);
	wire [7:0] hwstat;
	assign hwstat = {shutdown_flag_r, 1'b0, prot_r, sup_r, 1'b0, pres_r, 1'b0, heat_r};

	// The supervisor bit is only eligible for clearing if read outside the pulse.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd1_r      <= 1'b0;
			clr_fire_r <= 1'b0;
			snap_r     <= 8'h00;
			clr_mask_r <= 8'h00;
		end else begin
			rd1_r      <= rd_hwstat;
			snap_r     <= hwstat & {3'h7, ~por_active_r, 4'hF};
			clr_fire_r <= rd1_r;
			clr_mask_r <= rd1_r ? snap_r : 8'h00;
		end
	end

	wire [7:0] clr = clr_fire_r ? clr_mask_r : 8'h00;

	//==========================================================================
	// Sticky status flags; a new event in the clearing cycle wins.
	wire prot_set = vcc_prot_s | rst_prot_s;
	wire pres_set = present_seen_r & (present_s ^ present_prev_r);

	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			prot_r <= 1'b0;
			sup_r  <= 1'b1;
			pres_r <= 1'b0;
			heat_r <= 1'b0;
			shutdown_flag_r <= 1'b0;
		end else begin
			prot_r <= prot_set | (prot_r & ~clr[`TCS_HS_PROT]);
			sup_r  <= por_restart | (sup_r & ~clr[`TCS_HS_SUP]);
			pres_r <= pres_set | (pres_r & ~clr[`TCS_HS_PRES]);
			heat_r <= heat_s | (heat_r & ~clr[`TCS_HS_HEAT]);
			shutdown_flag_r <= ~shutdown_n_in_s | (shutdown_flag_r & ~clr[`TCS_HS_SHUTDOWN_FLAG]);
		end
	end

	//==========================================================================
	// Interrupt line: the supervisor flag only pulls it low during the pulse.
	reg irq_n_r;

	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_n_r <= 1'b0;
		end else begin
			irq_n_r <= ~(prot_r | pres_r | heat_r | shutdown_flag_r | (sup_r & por_active_r));
		end
	end

	//==========================================================================
	// Configuration and reload registers.
	reg [7:0] cfg_r;
	reg [7:0] reload_lo_r;
	reg [7:0] reload_mid_r;
	reg [7:0] reload_hi_r;

	wire wr_cfg = i_wr & (i_addr == `TCS_ADDR_TOCFG);

	// Reloads are write-only; changing them mid-count is the firmware's fault.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_r        <= `TCS_CFG_RESET;
			reload_lo_r  <= `TCS_RELOAD_RESET;
			reload_mid_r <= `TCS_RELOAD_RESET;
			reload_hi_r  <= `TCS_RELOAD_RESET;
		end else if (i_wr) begin
			case (i_addr)
				`TCS_ADDR_TOCFG: begin
					cfg_r <= i_wdata;
				end
				`TCS_ADDR_RELOAD_LO: begin
					reload_lo_r <= i_wdata;
				end
				`TCS_ADDR_RELOAD_MID: begin
					reload_mid_r <= i_wdata;
				end
				`TCS_ADDR_RELOAD_HI: begin
					reload_hi_r <= i_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	//==========================================================================
	// Counter stages: low, middle and high bytes of the time-out chain.
	wire [7:0] lo_val;
	wire [7:0] mid_val;
	wire [7:0] hi_val;
	wire       lo_zero;
	wire       lo_one;
	wire       mid_zero;
	wire       mid_one;
	wire       hi_zero;
	wire       hi_one;

	reg run1_r;
	reg arm1_r;
	reg run16_r;
	reg run24_r;

	wire code_c16  = (i_wdata == `TCS_CFG_C16);
	wire code_c816 = (i_wdata == `TCS_CFG_C8_C16);
	wire code_c24  = (i_wdata == `TCS_CFG_C24);

	wire tc1  = run1_r & i_count_tick & lo_one;
	wire tc16 = run16_r & i_count_tick & mid_one & hi_zero;
	wire tc24 = run24_r & i_count_tick & lo_one & mid_zero & hi_zero;

	wire lo_load  = (wr_cfg & (code_c816 | code_c24)) | tc1;
	wire lo_dec   = i_count_tick & (run1_r | run24_r);
	wire mid_load = wr_cfg & (code_c16 | code_c816 | code_c24);
	wire mid_dec  = i_count_tick & (run16_r | (run24_r & lo_zero));
	wire hi_dec   = i_count_tick & ((run16_r & mid_zero) | (run24_r & lo_zero & mid_zero));

	tcs_stage #(.WIDTH(8)) u_stage_lo (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_load     (lo_load),
		.i_load_val (reload_lo_r),
		.i_dec      (lo_dec),
		.o_val      (lo_val),
		.o_zero     (lo_zero),
		.o_one      (lo_one)
	);

	tcs_stage #(.WIDTH(8)) u_stage_mid (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_load     (mid_load),
		.i_load_val (reload_mid_r),
		.i_dec      (mid_dec),
		.o_val      (mid_val),
		.o_zero     (mid_zero),
		.o_one      (mid_one)
	);

	tcs_stage #(.WIDTH(8)) u_stage_hi (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_load     (mid_load),
		.i_load_val (reload_hi_r),
		.i_dec      (hi_dec),
		.o_val      (hi_val),
		.o_zero     (hi_zero),
		.o_one      (hi_one)
	);

	//==========================================================================
	// Mode control. Reload values are taken from the register written before the
	// configuration write, so firmware must load the reloads first.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			run1_r  <= 1'b0;
			arm1_r  <= 1'b0;
			run16_r <= 1'b0;
			run24_r <= 1'b0;
		end else if (wr_cfg) begin
			case (i_wdata)
				`TCS_CFG_KEEP1: begin
					run16_r <= 1'b0; // Counter 1 keeps its state.
					run24_r <= 1'b0;
				end
				`TCS_CFG_C16: begin
					run1_r  <= 1'b0;
					arm1_r  <= 1'b0;
					run16_r <= 1'b1;
					run24_r <= 1'b0;
				end
				`TCS_CFG_C8_C16: begin
					run1_r  <= 1'b0;
					arm1_r  <= 1'b1;
					run16_r <= 1'b1;
					run24_r <= 1'b0;
				end
				`TCS_CFG_C24: begin
					run1_r  <= 1'b0;
					arm1_r  <= 1'b0;
					run16_r <= 1'b0;
					run24_r <= 1'b1;
				end
				default: begin
					run1_r  <= 1'b0;
					arm1_r  <= 1'b0;
					run16_r <= 1'b0;
					run24_r <= 1'b0;
				end
			endcase
		end else begin
			if (arm1_r && start_bit) begin
				run1_r <= 1'b1;
				arm1_r <= 1'b0;
			end
			if (tc16) begin
				run16_r <= 1'b0;
			end
			if (tc24) begin
				run24_r <= 1'b0;
			end
		end
	end

	//==========================================================================
	// Time-out event pulses towards the UART status register.
	reg first_to_r;
	reg third_to_r;

	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			first_to_r <= 1'b0;
			third_to_r <= 1'b0;
		end else begin
			first_to_r <= tc1;
			third_to_r <= tc16 | tc24;
		end
	end

	//==========================================================================
	// Answer-to-reset window counter, restarted by each session start.
	reg [9:0] atr_cnt_r;
	reg       session_prev_r;
	reg       atr_min_r;
	reg       atr_max_r;

	// Counting saturates at the maximum so a slow card cannot wrap the window.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			atr_cnt_r      <= 10'h000;
			session_prev_r <= 1'b0;
			atr_min_r      <= 1'b0;
			atr_max_r      <= 1'b0;
		end else begin
			session_prev_r <= i_session_start;
			if (!i_session_start || !session_prev_r) begin
				atr_cnt_r <= 10'h000;
				atr_min_r <= 1'b0;
				atr_max_r <= 1'b0;
			end else if (i_card_clk_tick && !atr_max_r) begin
				atr_cnt_r <= atr_cnt_r + 10'h001;
				if (atr_cnt_r + 10'h001 == `TCS_ATR_MIN_CLOCKS) begin
					atr_min_r <= 1'b1;
				end
				if (atr_cnt_r + 10'h001 == ATR_MAX_CLOCKS[9:0]) begin
					atr_max_r <= 1'b1;
				end
			end
		end
	end

	//==========================================================================
	// Read data stand for exactly one cycle after the strobe.
	reg [7:0] rdata_r;

	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_r <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				`TCS_ADDR_TOCFG: begin
					rdata_r <= cfg_r;
				end
				`TCS_ADDR_HWSTAT: begin
					rdata_r <= hwstat;
				end
				default: begin
					rdata_r <= 8'h00;
				end
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	//==========================================================================
	// Outputs.
	assign o_rdata              = rdata_r;
	assign o_irq_n_out          = irq_n_r;
	assign o_first_timeout_flag = first_to_r;
	assign o_third_timeout_flag = third_to_r;
	assign o_atr_min_reached    = atr_min_r;
	assign o_atr_max_reached    = atr_max_r;
	assign o_por_active         = por_active_r;

endmodule // tcs_top
